/* File: src/psd_pkg.sv */
// constants and types for the program address segment decoder
// assumes a 64-bit pipeline and a 32-bit apb register port
package psd_pkg;
  localparam int unsigned VA_W     = 64;
  localparam int unsigned PA_W     = 36;
  localparam int unsigned K32_OFS  = 29;
  localparam int unsigned WIDE_MSB = 40;
  localparam int unsigned INT_W    = 3;

  localparam logic [7:0] REG_MODE     = 8'h00;
  localparam logic [7:0] REG_CFG      = 8'h04;
  localparam logic [7:0] REG_INT_STAT = 8'h08;
  localparam logic [7:0] REG_INT_MASK = 8'h0c;
  localparam logic [7:0] REG_LAST     = 8'h10;

  localparam int unsigned MODE_UW_BIT  = 0;
  localparam int unsigned MODE_SW_BIT  = 1;
  localparam int unsigned MODE_KW_BIT  = 2;
  localparam int unsigned MODE_PM_LSB  = 3;
  localparam int unsigned MODE_EXL_BIT = 5;
  localparam int unsigned MODE_ERL_BIT = 6;
  localparam int unsigned INT_ADDR_ERR = 0;
  localparam int unsigned INT_RSVD    = 1;
  localparam int unsigned INT_EXC     = 2;

  localparam logic [31:0] MODE_RST = 32'h0000_0040;
  localparam logic [2:0]  CFG_RST  = 3'h3;

  localparam logic [2:0] CCA_WT_NOALLOC = 3'h0;
  localparam logic [2:0] CCA_WT_ALLOC   = 3'h1;
  localparam logic [2:0] CCA_UNCACHED   = 3'h2;
  localparam logic [2:0] CCA_CACHED     = 3'h3;
  localparam logic [2:0] CCA_RSVD_MIN   = 3'h4;

  localparam logic [2:0] TOP3_UNCACHED = 3'h5;
  localparam logic [2:0] TOP3_CACHED   = 3'h4;
  localparam logic [2:0] TOP3_SUPER    = 3'h6;
  localparam logic [1:0] TOP2_USER     = 2'h0;
  localparam logic [1:0] TOP2_SUPER    = 2'h1;
  localparam logic [1:0] TOP2_PHYS     = 2'h2;

  typedef enum logic [1:0] {
    PSD_PM_KERNEL = 2'h0,
    PSD_PM_SUPER  = 2'h1,
    PSD_PM_USER   = 2'h2
  } psd_mode_t;

  typedef enum logic [3:0] {
    PSD_SEG_NONE        = 4'h0,
    PSD_SEG_USER        = 4'h1,
    PSD_SEG_SUP_USER    = 4'h2,
    PSD_SEG_SUP_32      = 4'h3,
    PSD_SEG_SUP_WIDE    = 4'h4,
    PSD_SEG_KERN_USER   = 4'h5,
    PSD_SEG_KUNM_CACHED = 4'h6,
    PSD_SEG_KUNM_UNCACH = 4'h7,
    PSD_SEG_KERN_SUP    = 4'h8,
    PSD_SEG_KERN_TOP    = 4'h9,
    PSD_SEG_KERN_PHYS   = 4'ha
  } psd_seg_t;

  typedef struct packed {
    logic            valid;
    logic            addr_err;
    logic            rsvd_attr;
    logic            mapped;
    logic [PA_W-1:0] paddr;
    logic [2:0]      cca;
    psd_seg_t        seg;
    psd_mode_t       mode;
    logic            wide;
  } psd_dec_t;
endpackage : psd_pkg

/* File: src/psd_decoder.sv */
// program address segment decoder: mode, segment, error and direct
// physical address for each pipeline address; mode state over apb.
// assumes one clock, synchronous inputs, a registered pipeline consumer.
//
// Decided for this implementation: the APB interface to the registers and the address map.
`timescale 1ns/10ps
module psd_decoder #(
  parameter int unsigned ADDR_W = 8
) (
  input  wire logic                 clk,
  input  wire logic                 rst,
  input  wire logic                 ce,
  input  wire logic                 psel,
  input  wire logic                 penable,
  input  wire logic                 pwrite,
  input  wire logic [ADDR_W-1:0]    paddr,
  input  wire logic [31:0]          pwdata,
  output logic [31:0]               prdata,
  output logic                      pready,
  output logic                      pslverr,
  input  wire logic                 req_valid,
  input  wire logic [63:0]          req_addr,
  input  wire logic                 exc_pulse,
  input  wire logic                 err_exc_pulse,
  input  wire logic                 eret_pulse,
  output psd_pkg::psd_dec_t         dec,
  output logic                      irq
);

  logic                     user_wide_ff;
  logic                     sup_wide_ff;
  logic                     kern_wide_ff;
  logic [1:0]               pm_field_ff;
  logic                     exception_level_flag_ff;
  logic                     error_level_flag_ff;
  logic [2:0]               cfg_cca_ff;
  logic [psd_pkg::INT_W-1:0] int_stat_ff;
  logic [psd_pkg::INT_W-1:0] int_mask_ff;
  logic [31:0]              prdata_ff;
  psd_pkg::psd_dec_t        dec_ff;

  // apb decode
  wire setup_ph  = psel & ~penable;
  wire access_ph = psel & penable;
  wire wr_en     = access_ph & pwrite;
  wire rd_setup  = setup_ph & ~pwrite;
  wire hit_mode  = paddr == ADDR_W'(psd_pkg::REG_MODE);
  wire hit_cfg   = paddr == ADDR_W'(psd_pkg::REG_CFG);
  wire hit_stat  = paddr == ADDR_W'(psd_pkg::REG_INT_STAT);
  wire hit_mask  = paddr == ADDR_W'(psd_pkg::REG_INT_MASK);
  wire hit_last  = paddr == ADDR_W'(psd_pkg::REG_LAST);
  wire hit_any   = hit_mode | hit_cfg | hit_stat | hit_mask | hit_last;
  wire wr_mode   = wr_en & hit_mode;
  wire wr_cfg    = wr_en & hit_cfg;
  wire wr_mask   = wr_en & hit_mask;
  wire rd_stat   = access_ph & ~pwrite & hit_stat;

  // kernel when any flag or field
  wire in_kernel = error_level_flag_ff | exception_level_flag_ff |
                   (pm_field_ff == psd_pkg::PSD_PM_KERNEL);
  wire in_super  = ~in_kernel & (pm_field_ff == psd_pkg::PSD_PM_SUPER);

  // an unused field code behaves as user, the least privileged map
  wire psd_pkg::psd_mode_t cur_mode =
    in_kernel ? psd_pkg::PSD_PM_KERNEL :
    in_super  ? psd_pkg::PSD_PM_SUPER  : psd_pkg::PSD_PM_USER;

  // wide bit of the current mode
  wire cur_wide = in_kernel ? kern_wide_ff :
                  in_super  ? sup_wide_ff  : user_wide_ff;

  wire [31:0] mode_word = {25'h0, error_level_flag_ff,
                           exception_level_flag_ff, pm_field_ff,
                           kern_wide_ff, sup_wide_ff, user_wide_ff};
  wire [31:0] last_word = {22'h0, dec_ff.wide, dec_ff.mode, dec_ff.seg,
                           dec_ff.mapped, dec_ff.rsvd_attr,
                           dec_ff.addr_err};
  wire [31:0] rd_mux =
    hit_mode ? mode_word :
    hit_cfg  ? {29'h0, cfg_cca_ff} :
    hit_stat ? {29'h0, int_stat_ff} :
    hit_mask ? {29'h0, int_mask_ff} :
    hit_last ? last_word : 32'h0;

  function automatic psd_pkg::psd_dec_t decode_addr(
    input logic [63:0]        va,
    input psd_pkg::psd_mode_t md,
    input logic               wide,
    input logic               error_level_flag,
    input logic [2:0]         k0cca
  );
    psd_pkg::psd_dec_t d;
    logic              hi_zero;
    logic              sext32;
    logic [2:0]        top3;
    d       = '0;
    d.valid = 1'b1;
    d.mode  = md;
    d.wide  = wide;
    hi_zero = ~|va[61:psd_pkg::WIDE_MSB];
    sext32  = &va[63:31];
    top3    = va[31:29];
    d.addr_err = 1'b1;
    unique case (md)
      psd_pkg::PSD_PM_USER:
      begin
        d.addr_err = wide ? |va[63:psd_pkg::WIDE_MSB] : va[31];
        d.mapped = 1'b1;
        d.seg    = psd_pkg::PSD_SEG_USER;
      end
      psd_pkg::PSD_PM_SUPER:
      begin
        d.mapped = 1'b1;
        if (wide)
        begin
          if (va[63:62] == psd_pkg::TOP2_USER)
          begin
            d.addr_err = ~hi_zero;
            d.seg      = psd_pkg::PSD_SEG_SUP_USER;
          end
          else if (va[63:62] == psd_pkg::TOP2_SUPER)
          begin
            d.addr_err = ~hi_zero;
            d.seg      = psd_pkg::PSD_SEG_SUP_WIDE;
          end
          else if (&va[63:32] && top3 == psd_pkg::TOP3_SUPER)
          begin
            d.addr_err = 1'b0;
            d.seg      = psd_pkg::PSD_SEG_SUP_32;
          end
        end
        else if (~va[31])
        begin
          d.addr_err = 1'b0;
          d.seg      = psd_pkg::PSD_SEG_SUP_USER;
        end
        else if (top3 == psd_pkg::TOP3_SUPER)
        begin
          d.addr_err = 1'b0;
          d.seg      = psd_pkg::PSD_SEG_SUP_32;
        end
      end
      psd_pkg::PSD_PM_KERNEL:
      begin
        d.addr_err = 1'b0;
        if (~wide | sext32)
        begin
          if (~va[31])
          begin
            d.seg = psd_pkg::PSD_SEG_KERN_USER;
            d.mapped = ~error_level_flag;
            d.paddr  = error_level_flag ? {4'h0, va[31:0]} : '0;
            d.cca    = error_level_flag ? psd_pkg::CCA_UNCACHED : 3'h0;
          end
          else if (top3 == psd_pkg::TOP3_CACHED ||
                   top3 == psd_pkg::TOP3_UNCACHED)
          begin
            d.paddr = {7'h0, va[psd_pkg::K32_OFS-1:0]};
            d.cca   = (top3 == psd_pkg::TOP3_CACHED) ? k0cca :
                      psd_pkg::CCA_UNCACHED;
            d.seg   = (top3 == psd_pkg::TOP3_CACHED) ?
                      psd_pkg::PSD_SEG_KUNM_CACHED :
                      psd_pkg::PSD_SEG_KUNM_UNCACH;
          end
          else
          begin
            d.mapped = 1'b1;
            d.seg    = (top3 == psd_pkg::TOP3_SUPER) ?
                       psd_pkg::PSD_SEG_KERN_SUP :
                       psd_pkg::PSD_SEG_KERN_TOP;
          end
        end
        else if (va[63:62] == psd_pkg::TOP2_PHYS)
        begin
          d.seg       = psd_pkg::PSD_SEG_KERN_PHYS;
          d.paddr     = va[psd_pkg::PA_W-1:0];
          d.cca       = va[61:59];
          d.rsvd_attr = va[61:59] >= psd_pkg::CCA_RSVD_MIN;
          d.addr_err  = d.rsvd_attr | (|va[58:psd_pkg::PA_W]);
        end
        else if (va[63:62] == psd_pkg::TOP2_USER)
        begin
          d.addr_err = ~hi_zero;
          d.seg      = psd_pkg::PSD_SEG_KERN_USER;
          d.mapped   = ~error_level_flag;
          d.paddr    = error_level_flag ? va[psd_pkg::PA_W-1:0] : '0;
          d.cca      = error_level_flag ? psd_pkg::CCA_UNCACHED : 3'h0;
        end
        else
        begin
          d.addr_err = ~hi_zero;
          d.mapped   = 1'b1;
          d.seg      = (va[63:62] == psd_pkg::TOP2_SUPER) ?
                       psd_pkg::PSD_SEG_KERN_SUP :
                       psd_pkg::PSD_SEG_KERN_TOP;
        end
      end
    endcase
    // an erroring address is never handed on or translated
    if (d.addr_err)
    begin
      d.mapped = 1'b0;
      d.paddr  = '0;
      d.cca    = 3'h0;
      d.seg    = psd_pkg::PSD_SEG_NONE;
    end
    return d;
  endfunction : decode_addr

  wire psd_pkg::psd_dec_t dec_raw = decode_addr(req_addr, cur_mode,
                                      cur_wide, error_level_flag_ff,
                                      cfg_cca_ff);
  psd_pkg::psd_dec_t nxt_dec;
  assign nxt_dec = req_valid ? dec_raw : '0;

  // exception sets a flag, return clears it
  wire exl_set = exc_pulse & ~err_exc_pulse;
  wire erl_clr = eret_pulse & error_level_flag_ff;
  wire exl_clr = eret_pulse & ~error_level_flag_ff;
  // hardware set wins over a same-cycle software write
  wire nxt_exl = exl_set | (~exl_clr & (wr_mode ?
                 pwdata[psd_pkg::MODE_EXL_BIT] : exception_level_flag_ff));
  wire nxt_erl = err_exc_pulse | (~erl_clr & (wr_mode ?
                 pwdata[psd_pkg::MODE_ERL_BIT] : error_level_flag_ff));

  wire [psd_pkg::INT_W-1:0] int_event;
  assign int_event[psd_pkg::INT_ADDR_ERR] = dec_raw.addr_err & req_valid;
  assign int_event[psd_pkg::INT_RSVD]     = dec_raw.rsvd_attr & req_valid;
  assign int_event[psd_pkg::INT_EXC]      = exc_pulse | err_exc_pulse;

  // only bits actually returned by the read are cleared, so an event
  // arriving between setup and access is not lost
  wire [psd_pkg::INT_W-1:0] nxt_int_stat;
  genvar gi;
  generate
    for (gi = 0; gi < psd_pkg::INT_W; gi++)
    begin : g_sticky
      assign nxt_int_stat[gi] = int_event[gi] |
        (int_stat_ff[gi] & ~(rd_stat & prdata_ff[gi]));
    end
  endgenerate

  always_ff @(posedge clk)
  begin
    if (rst)
      int_stat_ff <= '0;
    else if (ce)
      int_stat_ff <= nxt_int_stat;
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      user_wide_ff <= psd_pkg::MODE_RST[psd_pkg::MODE_UW_BIT];
      sup_wide_ff  <= psd_pkg::MODE_RST[psd_pkg::MODE_SW_BIT];
      kern_wide_ff <= psd_pkg::MODE_RST[psd_pkg::MODE_KW_BIT];
      pm_field_ff  <= psd_pkg::MODE_RST[psd_pkg::MODE_PM_LSB +: 2];
    end
    else if (ce && wr_mode)
    begin
      user_wide_ff <= pwdata[psd_pkg::MODE_UW_BIT];
      sup_wide_ff  <= pwdata[psd_pkg::MODE_SW_BIT];
      kern_wide_ff <= pwdata[psd_pkg::MODE_KW_BIT];
      pm_field_ff  <= pwdata[psd_pkg::MODE_PM_LSB +: 2];
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      exception_level_flag_ff <= psd_pkg::MODE_RST[psd_pkg::MODE_EXL_BIT];
      error_level_flag_ff     <= psd_pkg::MODE_RST[psd_pkg::MODE_ERL_BIT];
    end
    else if (ce)
    begin
      exception_level_flag_ff <= nxt_exl;
      error_level_flag_ff     <= nxt_erl;
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      cfg_cca_ff  <= psd_pkg::CFG_RST;
      int_mask_ff <= '0;
    end
    else if (ce)
    begin
      if (wr_cfg)
        cfg_cca_ff <= pwdata[2:0];
      if (wr_mask)
        int_mask_ff <= pwdata[psd_pkg::INT_W-1:0];
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      prdata_ff <= 32'h0;
      dec_ff    <= '0;
    end
    else if (ce)
    begin
      if (rd_setup)
        prdata_ff <= rd_mux;
      dec_ff <= nxt_dec;
    end
  end

  assign prdata  = prdata_ff;
  // zero wait states; an unmapped address answers with an error
  assign pready  = 1'b1;
  assign pslverr = access_ph & ~hit_any;
  assign dec     = dec_ff;
  assign irq     = |(int_stat_ff & int_mask_ff);

endmodule : psd_decoder

/* File: test/psd_checker.sv */
// checker: decode result assertions for the segment decoder
// assumes it is bound to psd_decoder and sees only its ports
`timescale 1ns/10ps
module psd_checker (
  input wire logic              clk,
  input wire logic              rst,
  input wire logic              ce,
  input wire logic              req_valid,
  input wire logic [63:0]       req_addr,
  input wire psd_pkg::psd_dec_t dec
);
  logic [63:0] va_ff;
  logic        us;
  logic        sv;
  logic        ok;
  logic        ku;
  assign us = dec.valid && dec.mode == psd_pkg::PSD_PM_USER;
  assign sv = dec.valid && dec.mode == psd_pkg::PSD_PM_SUPER;
  assign ok = dec.valid && !dec.addr_err;
  assign ku = dec.seg == psd_pkg::PSD_SEG_KUNM_CACHED
           || dec.seg == psd_pkg::PSD_SEG_KUNM_UNCACH;
  // address behind the result now on dec; frozen with the decoder
  always_ff @(posedge clk)
  begin
    if (ce)
      va_ff <= req_addr;
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  valid_follow_a : assert property (
    $past(ce) && !$past(rst) |-> dec.valid == $past(req_valid))
    else $error("decode valid does not follow request");
  user_narrow_a : assert property (
    us && !dec.wide |-> dec.addr_err == va_ff[31])
    else $error("user narrow range wrong");
  user_wide_a : assert property (
    us && dec.wide |-> dec.addr_err == (va_ff[63:40] != 24'h0))
    else $error("user wide range wrong");
  user_tlb_a : assert property (
    us && !dec.addr_err |-> dec.mapped && dec.cca == 3'h0)
    else $error("user address not sent to tlb");
  sup_narrow_a : assert property (
    sv && !dec.wide |-> dec.addr_err == (va_ff[31:30] == 2'h2
      || va_ff[31:29] == 3'h7))
    else $error("supervisor narrow range wrong");
  kunm_addr_a : assert property (
    ok && ku |-> !dec.mapped && dec.paddr == {7'h0, va_ff[28:0]})
    else $error("unmapped kernel address wrong");
  kunm_unc_a : assert property (
    ok && dec.seg == psd_pkg::PSD_SEG_KUNM_UNCACH |-> dec.cca == 3'h2)
    else $error("uncached segment cached");
  phys_a : assert property (
    ok && dec.seg == psd_pkg::PSD_SEG_KERN_PHYS |-> !dec.mapped
      && dec.paddr == va_ff[35:0] && dec.cca == va_ff[61:59])
    else $error("physical window decode wrong");
  rsvd_a : assert property (
    dec.valid && dec.mode == psd_pkg::PSD_PM_KERNEL && dec.wide
      && va_ff[63:61] == 3'h5 |-> dec.addr_err && dec.rsvd_attr)
    else $error("reserved attribute accepted");
endmodule : psd_checker
bind psd_decoder psd_checker chk_i (.clk(clk), .rst(rst), .ce(ce),
  .req_valid(req_valid), .req_addr(req_addr), .dec(dec));

/* File: test/psd_pipe_model.sv */
// pipeline model: issues program addresses and exception events
// assumes the decoder answers one clock edge after each request
`timescale 1ns/10ps
module psd_pipe_model (
  input  wire logic              clk,
  input  wire psd_pkg::psd_dec_t dec,
  output logic                   req_valid,
  output logic [63:0]            req_addr,
  output logic                   exc_pulse,
  output logic                   err_exc_pulse,
  output logic                   eret_pulse
);
  initial
  begin
    req_valid = 1'b0;
    req_addr = 64'h0;
    exc_pulse = 1'b0;
    err_exc_pulse = 1'b0;
    eret_pulse = 1'b0;
  end
  task automatic issue(input logic [63:0] a, output psd_pkg::psd_dec_t d);
    @(posedge clk);
    req_valid <= 1'b1;
    req_addr <= a;
    @(posedge clk);
    req_valid <= 1'b0;
    // idle address lines must not keep the last value
    req_addr <= ~a;
    @(negedge clk);
    d = dec;
  endtask : issue
  // entry and return are single-cycle events
  task automatic event_pulse(input logic [1:0] k);
    @(posedge clk);
    exc_pulse <= k == 2'h1;
    err_exc_pulse <= k == 2'h2;
    eret_pulse <= k == 2'h3;
    @(posedge clk);
    exc_pulse <= 1'b0;
    err_exc_pulse <= 1'b0;
    eret_pulse <= 1'b0;
  endtask : event_pulse
endmodule : psd_pipe_model

/* File: test/tb_top.sv */
// testbench: drives apb and the pipeline model, checks decode results
// assumes psd_decoder with zero-wait apb and one-cycle decode latency
`timescale 1ns/10ps
module tb_top;
  logic              clk;
  logic              rst;
  logic              ce;
  logic              psel;
  logic              penable;
  logic              pwrite;
  logic              pready;
  logic              pslverr;
  logic              irq;
  logic              er;
  logic [7:0]        paddr;
  logic [31:0]       pwdata;
  logic [31:0]       prdata;
  logic [31:0]       rd;
  logic              req_valid;
  logic              exc_pulse;
  logic              err_exc_pulse;
  logic              eret_pulse;
  logic [63:0]       req_addr;
  psd_pkg::psd_dec_t dec;
  psd_pkg::psd_dec_t d;
  int                mismatches = 0;
  int                tests_run = 0;
  initial clk = 1'b0;
  always #10 clk = ~clk;
  psd_decoder dut (.clk(clk), .rst(rst), .ce(ce), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .req_valid(req_valid), .req_addr(req_addr), .exc_pulse(exc_pulse),
    .err_exc_pulse(err_exc_pulse), .eret_pulse(eret_pulse), .dec(dec),
    .irq(irq));
  psd_pipe_model pipe (.clk(clk), .dec(dec), .req_valid(req_valid),
    .req_addr(req_addr), .exc_pulse(exc_pulse),
    .err_exc_pulse(err_exc_pulse), .eret_pulse(eret_pulse));
  task automatic chk(input string n, input logic [63:0] s,
                     input logic [63:0] e);
    tests_run++;
    if (s !== e)
    begin
      mismatches++;
      $display("BAD %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] wd);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1)
      @(posedge clk);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  // error results force address and attribute to zero, so skip them
  task automatic dchk(input logic [63:0] a, input logic e, input logic m,
                      input logic [35:0] pa, input logic [2:0] c);
    pipe.issue(a, d);
    chk("valid", d.valid, 1'b1);
    chk("addr_err", d.addr_err, e);
    chk("mapped", d.mapped, m);
    if (!e)
    begin
      chk("paddr", d.paddr, pa);
      chk("cca", d.cca, c);
    end
  endtask : dchk
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : give_verdict
  initial
  begin
    repeat (5000) @(posedge clk);
    mismatches++;
    give_verdict();
  end
  initial
  begin
    rst = 1'b1;
    ce = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    apb(1'b0, 8'h00, 32'h0);
    chk("mode_rst", rd, 32'h40);
    apb(1'b0, 8'h04, 32'h0);
    chk("cfg_rst", rd, 32'h3);
    apb(1'b0, 8'h14, 32'h0);
    chk("unmapped", {er, rd}, 33'h100000000);
    dchk(64'h8123_4567, 0, 0, 36'h0123_4567, 3'h3);
    chk("seg_k0", d.seg, psd_pkg::PSD_SEG_KUNM_CACHED);
    dchk(64'hbfff_fffc, 0, 0, 36'h1fff_fffc, 3'h2);
    apb(1'b1, 8'h04, 32'h0);
    dchk(64'h8000_0040, 0, 0, 36'h40, 3'h0);
    apb(1'b1, 8'h00, 32'h44);
    dchk(64'h12_3456_7890, 0, 0, 36'h2_3456_7890, 3'h2);
    apb(1'b1, 8'h00, 32'h04);
    dchk(64'h100, 0, 1, 36'h0, 3'h0);
    for (int i = 0; i < 4; i++)
      dchk({5'h10 | 5'(i), 23'h0, 36'h9_8765_4320}, 0, 0,
           36'h9_8765_4320, 3'(i));
    dchk(64'ha800_0000_0000_0000, 1, 0, 36'h0, 3'h0);
    dchk(64'hffff_ffff_a000_0040, 0, 0, 36'h40, 3'h2);
    apb(1'b1, 8'h0c, 32'h1);
    apb(1'b0, 8'h08, 32'h0);
    apb(1'b1, 8'h00, 32'h10);
    dchk(64'h7fff_fffc, 0, 1, 36'h0, 3'h0);
    dchk(64'h8000_0000, 1, 0, 36'h0, 3'h0);
    @(negedge clk);
    chk("irq_set", irq, 1'b1);
    apb(1'b0, 8'h08, 32'h0);
    chk("int_stat", rd, 32'h1);
    @(negedge clk);
    chk("irq_clr", irq, 1'b0);
    apb(1'b1, 8'h00, 32'h11);
    dchk(64'h8000_0000, 0, 1, 36'h0, 3'h0);
    chk("wide", d.wide, 1'b1);
    dchk(64'hff_ffff_fff8, 0, 1, 36'h0, 3'h0);
    dchk(64'h100_0000_0000, 1, 0, 36'h0, 3'h0);
    apb(1'b1, 8'h00, 32'h08);
    dchk(64'hdfff_fff0, 0, 1, 36'h0, 3'h0);
    dchk(64'he000_0000, 1, 0, 36'h0, 3'h0);
    apb(1'b1, 8'h00, 32'h0a);
    dchk(64'h4000_00ff_ffff_fff0, 0, 1, 36'h0, 3'h0);
    dchk(64'hffff_ffff_c000_0000, 0, 1, 36'h0, 3'h0);
    chk("seg_csup", d.seg, psd_pkg::PSD_SEG_SUP_32);
    dchk(64'h2000_0000_0000_0000, 1, 0, 36'h0, 3'h0);
    apb(1'b1, 8'h00, 32'h18);
    dchk(64'h8000_0000, 1, 0, 36'h0, 3'h0);
    pipe.event_pulse(2'h1);
    dchk(64'h8000_0000, 0, 0, 36'h0, 3'h0);
    chk("mode_exc", d.mode, psd_pkg::PSD_PM_KERNEL);
    pipe.event_pulse(2'h3);
    dchk(64'h8000_0000, 1, 0, 36'h0, 3'h0);
    pipe.event_pulse(2'h2);
    apb(1'b0, 8'h00, 32'h0);
    chk("mode_err", rd, 32'h58);
    pipe.event_pulse(2'h3);
    apb(1'b0, 8'h00, 32'h0);
    chk("mode_ret", rd, 32'h18);
    give_verdict();
  end
endmodule : tb_top
